// ===== hdl/adcctl_pkg.sv
package adcctl_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_RESULT = 8'h04;
    // Control register field positions
    localparam int CH_LSB = 0;
    localparam int CH_W = 4;
    localparam int POWER_BIT = 5;
    localparam int RC_BIT = 6;
    localparam int DONE_BIT = 7;
    // Reset values
    localparam logic [3:0] CHANNEL_RESET = 4'h0;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    // Conversion timing in conversion-clock cycles
    localparam int CONV_CYCLES = 32;
    localparam int SAMPLE_CYCLES = 12;
    localparam int SAR_BITS = 8;
    // Analog source codes seen by the multiplexer
    typedef enum logic [3:0] {
        SRC_TEMP = 4'b0000,
        SRC_PIN1 = 4'b0001,
        SRC_PIN2 = 4'b0010,
        SRC_PIN3 = 4'b0011,
        SRC_PIN4 = 4'b0100,
        SRC_PIN5 = 4'b0101,
        SRC_PIN6 = 4'b0110,
        SRC_SUPPLY = 4'b0111,
        SRC_REFHIGH = 4'b1000,
        SRC_REFMID = 4'b1001,
        SRC_REFLOW = 4'b1010
    } adcctl_source_type;
    // Conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_HOLD = 2'b10
    } adcctl_state_type;
endpackage

// ===== hdl/adcctl_channel_decode.sv
`timescale 1ns/100ps
// Channel field to one-hot source selects
module adcctl_channel_decode (
    // Channel field
    input wire logic [3:0] channelSelectField,
    // Decoded selects
    output adcctl_pkg::adcctl_source_type source,
    output logic [10:0] sourceOneHot
);
    // Codes 10 to 15 all fold onto the low reference
    always_comb begin
        if (channelSelectField >= 4'hA) begin
            source = adcctl_pkg::SRC_REFLOW;
        end else begin
            source = adcctl_pkg::adcctl_source_type'(channelSelectField);
        end
    end

    // One select line per source
    genvar i;
    generate
        for (i = 0; i < 11; i++) begin : gSel
            assign sourceOneHot[i] = (source == 4'(i));
        end
    endgenerate
endmodule

// ===== hdl/adcctl_top.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module adcctl_top (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power modes
    input wire logic waitMode,
    input wire logic stopMode,
    // RC oscillator tick, one-cycle enable
    input wire logic rcTick,
    // Analog front end
    input wire logic compareHigh,
    output logic [10:0] sourceSelect,
    output logic sampleSwitch,
    output logic [7:0] dacCode,
    output logic comparatorOn,
    output logic chargePumpOn,
    output logic rcOscOn
);
    // Control and status
    logic [3:0] channelSelectField_r;
    logic converterPowerOn_r;
    logic rcClockSelect_r;
    logic conversionDoneFlag_r;
    logic [7:0] conversionResult_r;
    // Sequencer
    adcctl_pkg::adcctl_state_type state_r;
    logic [4:0] cycleCount_r;
    logic [7:0] sar_r;
    logic [7:0] bitMask_r;
    logic [10:0] decodedSelect;
    adcctl_pkg::adcctl_source_type decodedSource;

    // APB decode; no wait states
    logic setupPhase;
    logic accessPhase;
    logic ctrlWrite;
    logic resultRead;
    logic addrValid;
    logic convTick;
    logic running;
    logic finish;
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign addrValid = (paddr == adcctl_pkg::OFF_CONTROL) || (paddr == adcctl_pkg::OFF_RESULT);
    assign ctrlWrite = accessPhase && pwrite && (paddr == adcctl_pkg::OFF_CONTROL);
    assign resultRead = accessPhase && !pwrite && (paddr == adcctl_pkg::OFF_RESULT);
    // Conversion clock: bus clock or RC tick; wait mode does not gate it
    assign convTick = rcClockSelect_r ? rcTick : 1'b1;
    assign running = converterPowerOn_r && !stopMode;
    assign finish = convTick && (state_r == adcctl_pkg::ST_HOLD) &&
        (cycleCount_r == 5'(adcctl_pkg::CONV_CYCLES - 1));

    adcctl_channel_decode uDecode (
        .channelSelectField(channelSelectField_r),
        .source(decodedSource),
        .sourceOneHot(decodedSelect)
    );

    // Control bits; stop does not touch them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channelSelectField_r <= adcctl_pkg::CHANNEL_RESET;
            converterPowerOn_r <= 1'b0;
            rcClockSelect_r <= 1'b0;
        end else if (ctrlWrite) begin
            channelSelectField_r <= pwdata[adcctl_pkg::CH_LSB +: adcctl_pkg::CH_W];
            converterPowerOn_r <= pwdata[adcctl_pkg::POWER_BIT];
            rcClockSelect_r <= pwdata[adcctl_pkg::RC_BIT];
        end
    end

    // Done flag: completion wins over a simultaneous result read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conversionDoneFlag_r <= 1'b0;
        end else if (ctrlWrite) begin
            conversionDoneFlag_r <= 1'b0;
        end else if (finish) begin
            conversionDoneFlag_r <= 1'b1;
        end else if (resultRead) begin
            conversionDoneFlag_r <= 1'b0;
        end
    end

    // Result loads together with the flag; bus writes never reach it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conversionResult_r <= adcctl_pkg::RESULT_RESET;
        end else if (finish && !ctrlWrite) begin
            conversionResult_r <= sar_r;
        end
    end

    // Sequencer helpers: the last sample tick, and any reason to start over
    logic sampleEnd;
    logic restart;
    assign sampleEnd = convTick && (state_r == adcctl_pkg::ST_SAMPLE) &&
        (cycleCount_r == 5'(adcctl_pkg::SAMPLE_CYCLES - 1));
    // A control write drops the running conversion without a result; stop does too, except on the finishing tick, which still stores it
    // A stopped conversion is never resumed half done; it restarts from idle at exit
    assign restart = ctrlWrite || !running;

    // Sequencer state: idle one tick, sample 12, hold 32, then sample again
    // The repeat needs no software action; only a control write or stop mode breaks the loop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= adcctl_pkg::ST_IDLE;
        end else if (restart) begin
            state_r <= adcctl_pkg::ST_IDLE;
        end else if (convTick) begin
            unique case (state_r)
                // One idle tick lets the new channel settle on the switches
                adcctl_pkg::ST_IDLE: begin
                    state_r <= adcctl_pkg::ST_SAMPLE;
                end
                adcctl_pkg::ST_SAMPLE: begin
                    if (sampleEnd) begin
                        state_r <= adcctl_pkg::ST_HOLD;
                    end
                end
                // Back to sampling at once keeps the period fixed
                adcctl_pkg::ST_HOLD: begin
                    if (finish) begin
                        state_r <= adcctl_pkg::ST_SAMPLE;
                    end
                end
                // Code 2'b11 is never entered; fall back to idle if it ever is
                default: begin
                    state_r <= adcctl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Cycle counter: restarts at each phase so hold spans the full 32 ticks
    // Without the clear at the end of sampling the hold would come out short
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cycleCount_r <= 5'h0;
        end else if (restart) begin
            cycleCount_r <= 5'h0;
        end else if (convTick) begin
            if ((state_r == adcctl_pkg::ST_IDLE) || sampleEnd || finish) begin
                cycleCount_r <= 5'h0;
            end else begin
                cycleCount_r <= cycleCount_r + 5'h1;
            end
        end
    end

    // Approximation register: one bit decided per tick, the rest of hold idles
    // The comparator answers the code now on the output, so each decision fits it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sar_r <= 8'h00;
            bitMask_r <= 8'h00;
        end else if (restart) begin
            sar_r <= 8'h00;
            bitMask_r <= 8'h00;
        end else if (sampleEnd) begin
            sar_r <= 8'h80;
            bitMask_r <= 8'h80;
        end else if (convTick && (state_r == adcctl_pkg::ST_HOLD) && !finish && (bitMask_r != 8'h00)) begin
            sar_r <= (compareHigh ? sar_r : (sar_r & ~bitMask_r)) | (bitMask_r >> 1);
            bitMask_r <= bitMask_r >> 1;
        end
    end

    // Trial code straight from the approximation flop
    // A second register here would make the comparator judge the previous code
    assign dacCode = sar_r;

    // Source select: nothing routed while the converter is off or stopped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sourceSelect <= 11'h000;
        end else begin
            sourceSelect <= running ? decodedSelect : 11'h000;
        end
    end

    // Sample switch: closed only in the sampling phase, open through hold
    // It lags the state by one cycle, so the window keeps its length
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sampleSwitch <= 1'b0;
        end else begin
            sampleSwitch <= running && (state_r == adcctl_pkg::ST_SAMPLE);
        end
    end

    // Comparator bias follows the running condition
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            comparatorOn <= 1'b0;
        end else begin
            comparatorOn <= running;
        end
    end

    // Charge pump: off in stop; restart relies on the device wake-up delay
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chargePumpOn <= 1'b0;
        end else begin
            chargePumpOn <= running;
        end
    end

    // RC oscillator runs on its select bit outside stop, not on the power bit, so it can settle before use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rcOscOn <= 1'b0;
        end else begin
            rcOscOn <= rcClockSelect_r && !stopMode;
        end
    end

    // APB ready: one access cycle after every setup, never a wait state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setupPhase;
        end
    end

    // APB error: unmapped addresses are refused and have no effect
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setupPhase && !addrValid;
        end
    end

    // Read data: built in setup, shown during access, zero otherwise
    // Unused bits read as zero so software may compare whole words
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= 32'h0000_0000;
            if (setupPhase && !pwrite) begin
                if (paddr == adcctl_pkg::OFF_CONTROL) begin
                    prdata[adcctl_pkg::CH_LSB +: adcctl_pkg::CH_W] <= channelSelectField_r;
                    prdata[adcctl_pkg::POWER_BIT] <= converterPowerOn_r;
                    prdata[adcctl_pkg::RC_BIT] <= rcClockSelect_r;
                    prdata[adcctl_pkg::DONE_BIT] <= conversionDoneFlag_r;
                end else if (paddr == adcctl_pkg::OFF_RESULT) begin
                    prdata[7:0] <= conversionResult_r;
                end
            end
        end
    end
endmodule

// ===== sim/adcctl_assertions.sv
`timescale 1ns/100ps
// Port checks of the converter control
module adcctl_assertions (
    // Clock and bus
    input wire logic clk,
    input wire logic resetn,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Modes and front end
    input wire logic stopMode,
    input wire logic [10:0] sourceSelect,
    input wire logic sampleSwitch,
    input wire logic comparatorOn,
    input wire logic chargePumpOn,
    input wire logic rcOscOn
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [5:0] quiet;
    // Cycles since a control write or stop, so timing checks skip restarts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quiet <= 6'h0;
        end else if ((pready && pwrite && paddr == 8'h00) || stopMode) begin
            quiet <= 6'h0;
        end else if (quiet != 6'h3F) begin
            quiet <= quiet + 6'h1;
        end
    end
    property p_samp; $fell(sampleSwitch) && !rcOscOn && quiet > 6'h02 |-> $past(sampleSwitch, 12) && !$past(sampleSwitch, 13); endproperty
    a_samp: assert property (p_samp) else $error("sample window length wrong");
    property p_hold; $rose(sampleSwitch) && !rcOscOn && quiet > 6'h28 |-> $past(sampleSwitch, 33) && !$past(sampleSwitch, 32); endproperty
    a_hold: assert property (p_hold) else $error("hold length wrong");
    property p_hot; $onehot0(sourceSelect); endproperty
    a_hot: assert property (p_hot) else $error("two sources selected");
    property p_src; sampleSwitch |-> sourceSelect != 11'h0; endproperty
    a_src: assert property (p_src) else $error("sampling with no source");
    property p_stopa; stopMode [*2] |-> !sampleSwitch && sourceSelect == 11'h0; endproperty
    a_stopa: assert property (p_stopa) else $error("converter runs in stop");
    property p_stopb; stopMode [*2] |-> !comparatorOn && !chargePumpOn; endproperty
    a_stopb: assert property (p_stopb) else $error("analog on in stop");
    property p_rst; $rose(resetn) |-> !comparatorOn && !chargePumpOn && !rcOscOn; endproperty
    a_rst: assert property (p_rst) else $error("on after reset");
    property p_go; pready && pwrite && paddr == 8'h00 && pwdata[5] && !pwdata[6] && !stopMode |-> ##[1:5] $rose(sampleSwitch); endproperty
    a_go: assert property (p_go) else $error("no restart after write");
    // Main scenarios reached
    c_stop: cover property (stopMode [*2] ##1 !stopMode);
    c_rc: cover property ($rose(sampleSwitch) && rcOscOn);
    c_read: cover property (pready && !pwrite && paddr == 8'h04);
endmodule
bind adcctl_top adcctl_assertions chk_i (.clk, .resetn, .pwrite, .paddr, .pwdata, .pready, .stopMode, .sourceSelect,
    .sampleSwitch, .comparatorOn, .chargePumpOn, .rcOscOn);

// ===== sim/adcctl_analog_model.sv
`timescale 1ns/100ps
// Analog side: steady level per source, sampled then held on a capacitor
module adcctl_analog_model (
    // Converter side
    input wire logic clk,
    input wire logic [10:0] sourceSelect,
    input wire logic sampleSwitch,
    input wire logic [7:0] dacCode,
    // Source levels and comparator
    input wire logic [7:0] levels [11],
    output logic compareHigh
);
    logic [7:0] held;
    // Plain inputs without pull-up: the level passes unchanged
    always_ff @(posedge clk) begin
        for (int i = 0; i < 11; i++) begin
            if (sampleSwitch && sourceSelect[i]) begin
                held <= levels[i];
            end
        end
    end
    assign compareHigh = held >= dacCode;
endmodule

// ===== sim/tb.sv
`timescale 1ns/100ps
// Channel table first, then abort, stop, wait, RC and bus cases
module tb;
    localparam logic [7:0] CTL = adcctl_pkg::OFF_CONTROL;
    localparam logic [7:0] RES = adcctl_pkg::OFF_RESULT;
    logic clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, waitMode = 1'h0;
    logic stopMode = 1'h0, rcTick = 1'h0, rcRun = 1'h0, pready, pslverr, compareHigh, sampleSwitch, errSeen;
    logic [7:0] paddr = 8'h0, dacCode;
    logic [31:0] pwdata = 32'h0, prdata, rd, span;
    logic [10:0] sourceSelect;
    logic [7:0] levels [11];
    int rowSrc [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 10, 10, 10, 10, 10};
    int miscompares = 0, checksDone = 0, n;
    // Clock; RC ticks at half rate so RC timing differs from bus timing
    always #50 clk = ~clk;
    always @(posedge clk) rcTick <= rcRun & ~rcTick;
    // Power outputs are judged by the checker
    adcctl_top dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .waitMode,
        .stopMode, .rcTick, .compareHigh, .sourceSelect, .sampleSwitch, .dacCode, .comparatorOn(), .chargePumpOn(),
        .rcOscOn());
    adcctl_analog_model far (.clk, .sourceSelect, .sampleSwitch, .dacCode, .levels, .compareHigh);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tmo(input logic hit);
        chk("wait", 32'h0, 32'(hit));
        if (hit) wrap_up();
    endtask
    // Setup then access, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        tmo(k >= 20);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdr(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic waitSw(input logic v);
        n = 0;
        while (sampleSwitch !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
        tmo(n >= 400);
    endtask
    task automatic waitDone;
        int k = 0;
        do begin
            rdr(CTL);
            k++;
        end while (rd[adcctl_pkg::DONE_BIT] !== 1'h1 && k < 150);
        tmo(k >= 150);
    endtask
    initial begin
        for (int i = 0; i < 11; i++) levels[i] = 8'(i * 23 + 9);
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        rdr(CTL);
        chk("control", 32'h0, rd & 32'hEF);
        rdr(RES);
        chk("result", 32'h0, rd);
        // Every channel value: routed source, then the converted level
        for (int c = 0; c < 16; c++) begin
            apb(1'h1, CTL, 32'h20 | 32'(c));
            waitSw(1'h0);
            waitSw(1'h1);
            chk("source", 32'h1 << rowSrc[c], 32'(sourceSelect));
            waitDone();
            rdr(RES);
            chk("result", 32'(levels[rowSrc[c]]), rd);
        end
        // A write in mid-hold clears done and discards the running value
        waitDone();
        waitSw(1'h1);
        waitSw(1'h0);
        repeat (20) @(posedge clk);
        apb(1'h1, CTL, 32'h22);
        rdr(CTL);
        chk("done", 32'h0, 32'(rd[adcctl_pkg::DONE_BIT]));
        waitDone();
        rdr(RES);
        chk("result", 32'(levels[2]), rd);
        // Stop in mid-hold: no result, registers kept, restart on exit
        apb(1'h1, CTL, 32'h23);
        waitSw(1'h0);
        waitSw(1'h1);
        waitSw(1'h0);
        stopMode <= 1'h1;
        repeat (60) @(posedge clk);
        rdr(CTL);
        chk("control", 32'h23, rd & 32'hEF);
        rdr(RES);
        chk("result", 32'(levels[2]), rd);
        stopMode <= 1'h0;
        waitDone();
        rdr(RES);
        chk("result", 32'(levels[3]), rd);
        // Wait mode: same pace, done stays; result is read-only, read clears done
        waitMode <= 1'h1;
        apb(1'h1, CTL, 32'h29);
        waitDone();
        waitSw(1'h0);
        waitSw(1'h1);
        waitSw(1'h0);
        span = n;
        waitSw(1'h1);
        chk("period", 32'(adcctl_pkg::SAMPLE_CYCLES + adcctl_pkg::CONV_CYCLES), span + n);
        rdr(CTL);
        chk("done", 32'h1, 32'(rd[adcctl_pkg::DONE_BIT]));
        apb(1'h1, RES, 32'hFF);
        rdr(RES);
        chk("result", 32'(levels[9]), rd);
        rdr(CTL);
        chk("done", 32'h0, 32'(rd[adcctl_pkg::DONE_BIT]));
        waitMode <= 1'h0;
        // RC clock, then converter left with power and RC select off
        rcRun <= 1'h1;
        apb(1'h1, CTL, 32'h65);
        waitDone();
        rdr(RES);
        chk("result", 32'(levels[5]), rd);
        apb(1'h1, CTL, 32'h0);
        rcRun <= 1'h0;
        rdr(8'h08);
        chk("error", 32'h1, 32'(errSeen));
        wrap_up();
    end
endmodule
